// ### rtl/dmc_pkg.sv
// Constants for the host-side controller of a 64K x 8 dynamic RAM module.
// Assumes one 125 MHz clock; every timing count is derived from nanoseconds here.
package dmc_pkg;

	// ****************************************************************
	// Clock and printed timing figures
	// ****************************************************************
	localparam int CLK_NS         = 8;
	localparam int T_RAS_MIN_NS   = 120;    // Row strobe low, least
	localparam int T_RAS_MAX_NS   = 10000;  // Row strobe low, longest
	localparam int T_CAS_MIN_NS   = 70;     // Column strobe low, least
	localparam int T_RP_NS        = 80;     // Row strobe precharge
	localparam int T_RC_NS        = 230;    // Full read or write cycle
	localparam int T_RCD_MIN_NS   = 30;     // Row low to column low
	localparam int T_CSH_NS       = 120;    // Row low to column strobe high
	localparam int T_RAH_NS       = 20;     // Row address hold
	localparam int T_CAC_NS       = 70;     // Access from column strobe
	localparam int T_RAC_NS       = 120;    // Access from row strobe
	localparam int T_PC_NS        = 120;    // Page-mode cycle
	localparam int T_CP_NS        = 40;     // Column strobe precharge
	localparam int T_REF_MS       = 4;      // Refresh interval
	localparam int T_PWRUP_US     = 100;    // Row strobe high before init

	// ****************************************************************
	// Derived cycle counts (least times rounded up, longest rounded down)
	// ****************************************************************
	localparam int RAS_MIN_CYC    = (T_RAS_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAS_MAX_CYC    = T_RAS_MAX_NS / CLK_NS;
	localparam int CAS_CYC        = (T_CAS_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int RCD_CYC        = (T_RCD_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CSH_CYC        = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAH_CYC        = (T_RAH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAC_CYC        = (T_CAC_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAC_CYC        = (T_RAC_NS + CLK_NS - 1) / CLK_NS;
	localparam int CP_A_CYC       = (T_CP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CP_B_CYC       = (T_PC_NS - T_CAS_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CP_CYC         = (CP_A_CYC > CP_B_CYC) ? CP_A_CYC : CP_B_CYC;
	localparam int PRE_A_CYC      = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PRE_B_CYC      = (T_RC_NS - T_RAS_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int PRE_CYC        = (PRE_A_CYC > PRE_B_CYC) ? PRE_A_CYC : PRE_B_CYC;
	localparam int PAGE_LIMIT_CYC = RAS_MAX_CYC - 2 * (CAS_CYC + CP_CYC);
	localparam int PWRUP_CYC      = T_PWRUP_US * 1000 / CLK_NS;

	// ****************************************************************
	// Array geometry and refresh pacing
	// ****************************************************************
	localparam int ROW_W          = 8;
	localparam int COL_W          = 6;
	localparam int MOD_W          = 2;      // Module select bits above the row
	localparam int NUM_MOD        = 4;
	localparam int ADDR_W         = MOD_W + ROW_W + COL_W;
	localparam int DATA_W         = 8;
	localparam int REF_ROWS       = 256;
	localparam int REF_ROW_CYC    = T_REF_MS * 1000000 / (REF_ROWS * CLK_NS);
	localparam int INIT_CYCLES    = 8;
	localparam int CNT_W          = 14;
	localparam int RAS_W          = 11;
	localparam int TMR_W          = 11;

	// ****************************************************************
	// Controller states
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_PWRUP   = 4'h0,
		ST_INIT_LO = 4'h1,
		ST_INIT_HI = 4'h2,
		ST_IDLE    = 4'h3,
		ST_ROW     = 4'h4,
		ST_RCD     = 4'h5,
		ST_CAS     = 4'h6,
		ST_CP      = 4'h7,
		ST_HOLD    = 4'h8,
		ST_PRE     = 4'h9,
		ST_REF     = 4'hA
	} dmc_state_t;

endpackage : dmc_pkg

// ### rtl/dmc_refresh_tick.sv
// Refresh pacer: raises a sticky due flag once per row interval and walks the row.
// Assumes the controller pulses ack once per finished row-only refresh.
`timescale 1ns/100ps

module dmc_refresh_tick
	import dmc_pkg::*;
(
	input  wire logic             mclk,     // 125 MHz clock
	input  wire logic             rst_n,    // Synchronous reset, active low
	input  wire logic             ack,      // Refresh of current row done
	output logic                  due,      // A row refresh is owed
	output logic [ROW_W-1:0]      row       // Row to refresh next
);

	typedef struct packed {
		logic [TMR_W-1:0] tmr;
		logic             due;
		logic [ROW_W-1:0] row;
	} dmc_tick_t;

	dmc_tick_t s_ff;
	dmc_tick_t nxt_s;

	// ****************************************************************
	// Interval timer and row walk
	// ****************************************************************
	// 256 evenly spaced rows cover every row once per interval
	always_comb begin
		nxt_s = s_ff;
		nxt_s.tmr = s_ff.tmr + TMR_W'(1);
		if (ack) begin
			nxt_s.due = 1'b0;
			nxt_s.row = s_ff.row + ROW_W'(1);
		end
		// Set after clear, so a tick in the ack cycle is kept
		if (s_ff.tmr == TMR_W'(REF_ROW_CYC - 1)) begin
			nxt_s.tmr = '0;
			nxt_s.due = 1'b1;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign due = s_ff.due;
	assign row = s_ff.row;

endmodule : dmc_refresh_tick

// ### rtl/dmc_ctrl.sv
// Host controller driving up to four 64K x 8 dynamic RAM modules by their pins.
// Assumes pin inputs are synchronous to mclk and the user holds a request until done.
//
// Overview of operation
// - Row and column addresses stand stable before their strobes fall.
// - Write-select high reads, low writes; set for every access.
// - Writes are early: write-select low before column strobe falls.
// - Every row is refreshed at least once per four milliseconds.
// - Row-only refresh walks 256 rows with column strobes high.
// - Page mode keeps the row open and pulses column strobe per column.
// - Row strobe is shared; a decoded column strobe selects one module.
// - Power-up: row strobe high 100 us, then eight row strobe cycles.
// - Row strobe low lasts 120 ns to 10,000 ns.
// - Column strobe low lasts 70 ns to 10,000 ns.
`timescale 1ns/100ps

module dmc_ctrl
	import dmc_pkg::*;
#(
	parameter int PWRUP_CYCLES = PWRUP_CYC   // Row strobe high time at power-up
)(
	input  wire logic              mclk,                       // 125 MHz clock
	input  wire logic              rst_n,                      // Synchronous reset, active low
	input  wire logic              req,                        // Access request, held until done
	input  wire logic              req_we,                     // 1 write, 0 read
	input  wire logic [ADDR_W-1:0] req_addr,                   // Module, row, column
	input  wire logic [DATA_W-1:0] req_wdata,                  // Write byte
	output logic                   done,                       // One-cycle end of access
	output logic [DATA_W-1:0]      rd_data,                    // Read byte, valid with done
	output logic                   init_done,                  // Power-up sequence finished
	output logic                   row_strobe_n,               // Shared row strobe
	output logic [NUM_MOD-1:0]     col_strobe_n,               // Column strobe per module
	output logic                   write_select_n,             // Low selects write
	output logic [ROW_W-1:0]       multiplexed_address_lines,  // Row or column address
	input  wire logic [DATA_W-1:0] shared_data_lines_i,        // Data lines as seen
	output logic [DATA_W-1:0]      shared_data_lines_o,        // Data we drive
	output logic                   shared_data_lines_oe        // High while we drive
);

	typedef struct packed {
		dmc_state_t         st;
		logic [CNT_W-1:0]   cnt;
		logic [RAS_W-1:0]   ras_cnt;
		logic [3:0]         init_cnt;
		logic [ROW_W-1:0]   op_row;
		logic               op_we;
		logic               op_ref;
		logic               op_page;
		logic               ras_n;
		logic [NUM_MOD-1:0] cas_n;
		logic               we_n;
		logic [ROW_W-1:0]   addr;
		logic [DATA_W-1:0]  dq_o;
		logic               dq_oe;
		logic [DATA_W-1:0]  rd_data;
		logic               done;
		logic               init_done;
		logic               ref_ack;
	} dmc_ctrl_t;

	dmc_ctrl_t          s_ff;
	dmc_ctrl_t          nxt_s;
	logic               ref_due;
	logic [ROW_W-1:0]   ref_row;
	logic [NUM_MOD-1:0] mod_sel;
	logic [ROW_W-1:0]   req_row;
	logic [ROW_W-1:0]   req_col_lines;

	// ****************************************************************
	// Address split and module decode
	// ****************************************************************
	assign req_row       = req_addr[COL_W +: ROW_W];
	assign req_col_lines = {1'b0, req_addr[COL_W-1:0], 1'b0};

	// One column strobe per module; row strobe goes to all of them
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
			assign mod_sel[gi] = (req_addr[ADDR_W-1 -: MOD_W] == MOD_W'(gi));
		end
	endgenerate

	// ****************************************************************
	// Refresh pacing
	// ****************************************************************
	dmc_refresh_tick u_tick (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ack   (s_ff.ref_ack),
		.due   (ref_due),
		.row   (ref_row)
	);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Every pin is a flop so strobe edges line up exactly with the counts
	always_comb begin
		nxt_s         = s_ff;
		nxt_s.done    = 1'b0;
		nxt_s.ref_ack = 1'b0;
		nxt_s.cnt     = s_ff.cnt + CNT_W'(1);
		// Time since row strobe fell; saturates, never wraps
		if (s_ff.ras_n) begin
			nxt_s.ras_cnt = '0;
		end else if (s_ff.ras_cnt != '1) begin
			nxt_s.ras_cnt = s_ff.ras_cnt + RAS_W'(1);
		end
		unique case (s_ff.st)
			ST_PWRUP: begin
				if (s_ff.cnt == CNT_W'(PWRUP_CYCLES - 1)) begin
					nxt_s.ras_n = 1'b0;
					nxt_s.cnt   = '0;
					nxt_s.st    = ST_INIT_LO;
				end
			end
			ST_INIT_LO: begin
				if (s_ff.cnt == CNT_W'(RAS_MIN_CYC - 1)) begin
					nxt_s.ras_n = 1'b1;
					nxt_s.cnt   = '0;
					nxt_s.st    = ST_INIT_HI;
				end
			end
			ST_INIT_HI: begin
				if (s_ff.cnt == CNT_W'(PRE_CYC - 1)) begin
					nxt_s.cnt = '0;
					if (s_ff.init_cnt == 4'(INIT_CYCLES - 1)) begin
						nxt_s.init_done = 1'b1;
						nxt_s.st        = ST_IDLE;
					end else begin
						nxt_s.init_cnt = s_ff.init_cnt + 4'h1;
						nxt_s.ras_n    = 1'b0;
						nxt_s.st       = ST_INIT_LO;
					end
				end
			end
			ST_IDLE: begin
				// Refresh first; a late row costs data, a late access costs time
				if (ref_due) begin
					nxt_s.addr   = ref_row;
					nxt_s.op_ref = 1'b1;
					nxt_s.st     = ST_ROW;
				end else if (req) begin
					nxt_s.addr   = req_row;
					nxt_s.op_row = req_row;
					nxt_s.op_we  = req_we;
					nxt_s.op_ref = 1'b0;
					nxt_s.st     = ST_ROW;
				end
			end
			ST_ROW: begin
				// Address has stood one cycle before the strobe falls
				nxt_s.ras_n = 1'b0;
				nxt_s.cnt   = '0;
				nxt_s.st    = s_ff.op_ref ? ST_REF : ST_RCD;
			end
			ST_RCD: begin
				if (s_ff.cnt == CNT_W'(RAH_CYC - 1)) begin
					nxt_s.addr  = req_col_lines;
					nxt_s.we_n  = ~s_ff.op_we;
					nxt_s.dq_o  = req_wdata;
					nxt_s.dq_oe = s_ff.op_we;
				end
				if (s_ff.cnt == CNT_W'(RCD_CYC - 1)) begin
					nxt_s.cas_n = ~mod_sel;
					nxt_s.cnt   = '0;
					nxt_s.st    = ST_CAS;
				end
			end
			ST_CAS: begin
				// Writes too keep column strobe low until 120 ns after row fell
				// Reads also wait out the access time from the row strobe
				if (s_ff.cnt >= CNT_W'(CAS_CYC - 1) &&
				    s_ff.ras_cnt >= RAS_W'(CSH_CYC - 1) &&
				    (s_ff.op_we || (s_ff.cnt >= CNT_W'(CAC_CYC - 1) &&
				                    s_ff.ras_cnt >= RAS_W'(RAC_CYC - 1)))) begin
					if (!s_ff.op_we) begin
						nxt_s.rd_data = shared_data_lines_i;
					end
					nxt_s.cas_n = '1;
					nxt_s.we_n  = 1'b1;
					nxt_s.dq_oe = 1'b0;
					nxt_s.done  = 1'b1;
					nxt_s.cnt   = '0;
					nxt_s.st    = ST_CP;
				end
			end
			ST_CP: begin
				// Decide late so the user has seen done and shown the next request
				if (s_ff.cnt == CNT_W'(CP_CYC - 2)) begin
					nxt_s.op_page = req && !ref_due && req_row == s_ff.op_row &&
					                s_ff.ras_cnt < RAS_W'(PAGE_LIMIT_CYC);
					if (nxt_s.op_page) begin
						nxt_s.addr  = req_col_lines;
						nxt_s.op_we = req_we;
						nxt_s.we_n  = ~req_we;
						nxt_s.dq_o  = req_wdata;
						nxt_s.dq_oe = req_we;
					end
				end
				if (s_ff.cnt == CNT_W'(CP_CYC - 1)) begin
					nxt_s.cnt = '0;
					if (s_ff.op_page) begin
						nxt_s.cas_n = ~mod_sel;
						nxt_s.st    = ST_CAS;
					end else begin
						nxt_s.st = ST_HOLD;
					end
				end
			end
			ST_HOLD: begin
				if (s_ff.ras_cnt >= RAS_W'(RAS_MIN_CYC - 1)) begin
					nxt_s.ras_n = 1'b1;
					nxt_s.cnt   = '0;
					nxt_s.st    = ST_PRE;
				end
			end
			ST_PRE: begin
				if (s_ff.cnt == CNT_W'(PRE_CYC - 1)) begin
					nxt_s.st = ST_IDLE;
				end
			end
			ST_REF: begin
				// Column strobes stay high, so the modules never drive data
				if (s_ff.cnt == CNT_W'(RAS_MIN_CYC - 1)) begin
					nxt_s.ras_n   = 1'b1;
					nxt_s.ref_ack = 1'b1;
					nxt_s.cnt     = '0;
					nxt_s.st      = ST_PRE;
				end
			end
			default: begin
				nxt_s = s_ff;
				nxt_s.st = ST_PWRUP;
			end
		endcase
	end

	// State register; reset leaves every strobe inactive
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_ff       <= '0;
			s_ff.st    <= ST_PWRUP;
			s_ff.ras_n <= 1'b1;
			s_ff.cas_n <= '1;
			s_ff.we_n  <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ****************************************************************
	// Outputs, all straight from the state register
	// ****************************************************************
	assign done                      = s_ff.done;
	assign rd_data                   = s_ff.rd_data;
	assign init_done                 = s_ff.init_done;
	assign row_strobe_n              = s_ff.ras_n;
	assign col_strobe_n              = s_ff.cas_n;
	assign write_select_n            = s_ff.we_n;
	assign multiplexed_address_lines = s_ff.addr;
	assign shared_data_lines_o       = s_ff.dq_o;
	assign shared_data_lines_oe      = s_ff.dq_oe;

endmodule : dmc_ctrl

// ### tb/dmc_dram_model.sv
// Behavioural model of four 64K x 8 dynamic RAM modules sharing one row strobe.
// Assumes the bench resolves the data wire from this model and the controller.
`timescale 1ns/100ps

module dmc_dram_model
	import dmc_pkg::*;
(
	input  wire logic               row_strobe_n,    // Shared row strobe
	input  wire logic [NUM_MOD-1:0] col_strobe_n,    // Column strobe per module
	input  wire logic               write_select_n,  // Low selects write
	input  wire logic [ROW_W-1:0]   addr,            // Row or column address
	input  wire logic [DATA_W-1:0]  dq_in,           // Data wire level
	output logic [DATA_W-1:0]       dq_out           // Our drive, junk when off
);
	// ****************************************************************
	// Array and strobe latches
	// ****************************************************************
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [ROW_W-1:0]  row_q;
	logic [COL_W-1:0]  col_q;
	logic [MOD_W-1:0]  mod_q;
	logic              cas_all_hi;

	assign cas_all_hi = &col_strobe_n;
	initial dq_out = 8'h00;

	// Row opens at row strobe fall; a row-only pulse is a refresh
	always @(negedge row_strobe_n) row_q = addr;

	// Column, module and write byte taken at column strobe fall
	always @(negedge cas_all_hi) begin
		col_q = addr[6:1];
		for (int m = 0; m < NUM_MOD; m++)
			if (!col_strobe_n[m]) mod_q = MOD_W'(m);
		if (!write_select_n) mem[{mod_q, row_q, col_q}] = dq_in;
	end

	// Read data only after column access time; early samples see junk
	always @(negedge cas_all_hi) begin
		if (write_select_n) begin
			#(T_CAC_NS);
			if (!cas_all_hi) dq_out = mem[{mod_q, row_q, col_q}];
		end
	end

	// Released lines do not keep the last value
	always @(posedge cas_all_hi) dq_out = ~dq_out;
endmodule : dmc_dram_model

// ### tb/dmc_ctrl_assertions.sv
// Pin-level checker for the dynamic RAM controller.
// Assumes it is bound into dmc_ctrl and sees only its ports.
`timescale 1ns/100ps

module dmc_ctrl_chk
	import dmc_pkg::*;
(
	input wire logic               mclk,                       // Clock
	input wire logic               rst_n,                      // Reset, active low
	input wire logic               done,                       // Access finished
	input wire logic               init_done,                  // Power-up finished
	input wire logic               row_strobe_n,               // Row strobe
	input wire logic [NUM_MOD-1:0] col_strobe_n,               // Column strobes
	input wire logic               write_select_n,             // Low selects write
	input wire logic [ROW_W-1:0]   multiplexed_address_lines,  // Address lines
	input wire logic               shared_data_lines_oe        // We drive data
);
	// ****************************************************************
	// Pulse width counters
	// ****************************************************************
	logic [RAS_W-1:0] lo_ff;
	logic [RAS_W-1:0] hi_ff;
	logic [RAS_W-1:0] cl_ff;
	logic             cas_hi;

	assign cas_hi = &col_strobe_n;

	// Saturating high count: idle gaps may be long
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lo_ff <= '0;
			hi_ff <= '0;
			cl_ff <= '0;
		end else begin
			lo_ff <= row_strobe_n ? '0 : lo_ff + 1'b1;
			hi_ff <= !row_strobe_n ? '0 : ((&hi_ff) ? hi_ff : hi_ff + 1'b1);
			cl_ff <= cas_hi ? '0 : cl_ff + 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_ras_width;
		$rose(row_strobe_n) |-> lo_ff >= RAS_MIN_CYC && lo_ff <= RAS_MAX_CYC;
	endproperty
	a_ras_width: assert property (p_ras_width) else $error("row strobe low width");
	property p_ras_pre;
		$fell(row_strobe_n) |-> hi_ff >= PRE_CYC;
	endproperty
	a_ras_pre: assert property (p_ras_pre) else $error("row strobe precharge short");
	property p_cas_width;
		$rose(cas_hi) |-> cl_ff >= CAS_CYC && cl_ff <= RAS_MAX_CYC;
	endproperty
	a_cas_width: assert property (p_cas_width) else $error("column strobe low width");
	property p_csh;
		$rose(cas_hi) |-> !row_strobe_n && lo_ff >= CSH_CYC;
	endproperty
	a_csh: assert property (p_csh) else $error("column strobe rose too soon after row strobe");
	property p_cas_in_ras;
		!cas_hi |-> !row_strobe_n && lo_ff >= RCD_CYC;
	endproperty
	a_cas_in_ras: assert property (p_cas_in_ras) else $error("column strobe outside row");
	property p_one_mod;
		$onehot0(~col_strobe_n);
	endproperty
	a_one_mod: assert property (p_one_mod) else $error("two modules selected");
	property p_oe_write;
		shared_data_lines_oe |-> !write_select_n;
	endproperty
	a_oe_write: assert property (p_oe_write) else $error("data driven in read");
	property p_early_wr;
		$fell(cas_hi) && !write_select_n |-> $past(!write_select_n) && shared_data_lines_oe;
	endproperty
	a_early_wr: assert property (p_early_wr) else $error("write not early");
	property p_col_hold;
		!cas_hi |-> $stable(multiplexed_address_lines) && $stable(write_select_n)
			&& !multiplexed_address_lines[0] && !multiplexed_address_lines[7];
	endproperty
	a_col_hold: assert property (p_col_hold) else $error("column address moved");
	property p_done;
		done |-> $rose(cas_hi) ##1 !done;
	endproperty
	a_done: assert property (p_done) else $error("done not at column strobe rise");
	property p_init;
		!init_done |-> cas_hi && !done && write_select_n && !shared_data_lines_oe;
	endproperty
	a_init: assert property (p_init) else $error("access before init");
endmodule : dmc_ctrl_chk

bind dmc_ctrl dmc_ctrl_chk dmc_ctrl_chk_i (.mclk(mclk), .rst_n(rst_n), .done(done), .init_done(init_done),
	.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_select_n(write_select_n),
	.multiplexed_address_lines(multiplexed_address_lines), .shared_data_lines_oe(shared_data_lines_oe));

// ### tb/tb_top.sv
// Self-checking bench: controller against the behavioural RAM module model.
// Assumes one clock; the data wire is resolved here from both drivers.
`timescale 1ns/100ps

module tb_top;
	import dmc_pkg::*;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	localparam int      PWR = 50;  // Short power-up wait keeps the run brief
	logic               mclk = 1'b0;
	logic               rst_n = 1'b0;
	logic               req = 1'b0;
	logic               req_we = 1'b0;
	logic [ADDR_W-1:0]  req_addr = '0;
	logic [DATA_W-1:0]  req_wdata = '0;
	logic               done, init_done, ras_n, we_n, oe;
	logic [NUM_MOD-1:0] cas_n;
	logic [ROW_W-1:0]   addr, fall_row;
	logic [DATA_W-1:0]  rd_data, dq_o, m_out, got;
	wire  [DATA_W-1:0]  dq = oe ? dq_o : m_out;
	int                 err_count = 0, tests_run = 0, cycles = 0, ras_falls = 0, first_fall = 0, fall_cyc = 0;
	logic [ADDR_W-1:0]  ta [6] = '{16'h0000, 16'hFFFF, 16'h403F, 16'h8FC0, 16'hC555, 16'h2AAA};
	logic [DATA_W-1:0]  td [6] = '{8'hA5, 8'h5A, 8'hFF, 8'h00, 8'h3C, 8'h81};

	dmc_ctrl #(.PWRUP_CYCLES(PWR)) dmc_ctrl_i (.mclk(mclk), .rst_n(rst_n), .req(req), .req_we(req_we),
		.req_addr(req_addr), .req_wdata(req_wdata), .done(done), .rd_data(rd_data), .init_done(init_done),
		.row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_select_n(we_n), .multiplexed_address_lines(addr),
		.shared_data_lines_i(dq), .shared_data_lines_o(dq_o), .shared_data_lines_oe(oe));
	dmc_dram_model dmc_dram_model_i (.row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_select_n(we_n),
		.addr(addr), .dq_in(dq), .dq_out(m_out));

	always #4 mclk = ~mclk;
	// Cycle count and hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end
	// Row strobe falls: how many, when, which row
	always @(negedge ras_n) begin
		if (ras_falls == 0) first_fall = cycles;
		ras_falls++;
		fall_cyc = cycles;
		fall_row = addr;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		tests_run++;
		if (exp !== seen) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask : tick
	// Request held until done; keep leaves it up for a page follow-on
	task automatic acc(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd, input logic keep);
		int n;
		n = 0;
		req = 1'b1;
		req_we = we;
		req_addr = a;
		req_wdata = wd;
		do begin
			tick();
			n++;
		end while (done !== 1'b1 && n < 200);
		chk("done", 16'h0001, done);
		got = rd_data;
		if (!keep) begin
			req = 1'b0;
			tick();
		end
	endtask : acc
	task automatic wait_fall(output int c, output logic [ROW_W-1:0] r);
		int n0, n;
		n0 = ras_falls;
		n = 0;
		while (ras_falls == n0 && n < 2100) begin
			tick();
			n++;
		end
		c = fall_cyc;
		r = fall_row;
	endtask : wait_fall

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_init();
		int n;
		n = 0;
		while (init_done !== 1'b1 && n < 1000) begin
			tick();
			n++;
		end
		chk("init_done", 16'h0001, init_done);
		chk("init_ras_cycles", 16'h0008, 16'(ras_falls));
		chk("pwrup_wait", 16'h0001, 16'(first_fall >= PWR + 4));
	endtask : t_init
	task automatic t_wr();
		for (int i = 0; i < 6; i++) acc(1'b1, ta[i], td[i], 1'b0);
	endtask : t_wr
	// Idle refresh: consecutive rows, paced, no column strobe
	task automatic t_ref();
		int c1, c2;
		logic [ROW_W-1:0] r1, r2;
		wait_fall(c1, r1);
		wait_fall(c2, r2);
		chk("refresh_row_step", ROW_W'(r1 + 1'b1), r2);
		chk("refresh_gap_ok", 16'h0001, 16'((c2 - c1) <= REF_ROW_CYC));
		repeat (14) begin
			tick();
			chk("refresh_cas_n", 16'h000F, cas_n);
		end
	endtask : t_ref
	// Runs right after a refresh, so none is due to break the page
	task automatic t_page();
		int r0;
		r0 = ras_falls;
		acc(1'b1, 16'h1234, 8'h11, 1'b1);
		acc(1'b1, 16'h1235, 8'h22, 1'b1);
		acc(1'b0, 16'h1234, 8'h00, 1'b1);
		chk("page_rd0", 16'h0011, got);
		acc(1'b0, 16'h1235, 8'h00, 1'b0);
		chk("page_rd1", 16'h0022, got);
		chk("page_ras_falls", 16'h0001, 16'(ras_falls - r0));
	endtask : t_page
	// Read back after refresh: corners of module, row and column
	task automatic t_rd();
		for (int i = 0; i < 6; i++) begin
			acc(1'b0, ta[i], 8'h00, 1'b0);
			chk("rd_data", td[i], got);
		end
	endtask : t_rd

	task automatic stop_test();
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	initial begin
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		t_init();
		t_wr();
		t_ref();
		t_page();
		t_rd();
		stop_test();
	end
endmodule : tb_top
